/* rsps_scan_regs.vh */
// Purpose: constants for the rolling shutter pixel scan block
// Assumes: 25 MHz ref_clk
// Notes: array includes dummy rows and columns
`ifndef RSPS_SCAN_REGS_VH
`define RSPS_SCAN_REGS_VH
`define RSPS_COLS        11'h0_506
`define RSPS_ROWS        11'h0_406
`define RSPS_FIRST_POS   11'h0_000
`define RSPS_SUB_STEP    11'h0_004
`define RSPS_DATA_W      10
`define RSPS_PTR_W       11
`define RSPS_FIFO_DEPTH  32
`define RSPS_FIFO_AW     5
`define RSPS_LINE_NS     135000
`define RSPS_CLK_NS      40
`define RSPS_LINE_CYC    ((`RSPS_LINE_NS) / (`RSPS_CLK_NS))
`endif

/* rsps_fifo.v */
// Purpose: name kept for the pixel word buffer
// Assumes: nothing
// Notes: the buffer module rsps_fifo sits beside the scan logic in rsps_pixel_scan.v

/* rsps_pixel_scan.v */
// Purpose: row/column pointers of a rolling shutter pixel array, pixel word output
// Assumes: pointer clocks and syncs come from an outside controller, async to ref_clk
// Notes: pin inputs pass three flops; an edge counts when stages two and three agree
// Function
// - readout row pointer selects the row being delivered
// - column pointer selects one pixel in the readout row
// - separate reset row pointer selects the row being reset
// - integration time is the row distance between reset and readout pointers
// - each pointer clock pulse advances that pointer by one, or by four in viewfinder mode
// - a sync pulse returns a pointer to its first position
// - array spans 1286 columns by 1030 rows, six dummy each way
// - viewfinder mode subsamples 4:1 each way, 320 by 256
// - each converted pixel is delivered as a 10-bit word
// - exposure adjusts in whole line-time steps, 135 us
`timescale 1ns/1ns
`default_nettype none
`include "rsps_scan_regs.vh"
module rsps_pixel_scan (
    input  wire                     ref_clk,
    input  wire                     resetn,
    input  wire                     readRowClk,
    input  wire                     readRowSync,
    input  wire                     resetRowClk,
    input  wire                     resetRowSync,
    input  wire                     colClk,
    input  wire                     colSync,
    input  wire                     viewfinderEn,
    input  wire [`RSPS_DATA_W-1:0]  pixelSample,
    input  wire                     pixelReady,
    output reg                      pixelValid,
    output reg  [`RSPS_DATA_W-1:0]  pixelData,
    output reg  [`RSPS_PTR_W-1:0]   readRow,
    output reg  [`RSPS_PTR_W-1:0]   resetRow,
    output reg  [`RSPS_PTR_W-1:0]   column,
    output reg  [`RSPS_PTR_W-1:0]   integLines,
    output reg                      overflow
);
    localparam NPIN = 7;
    wire [NPIN-1:0] pinIn;
    reg  [NPIN-1:0] s1_reg;
    reg  [NPIN-1:0] s2_reg;
    reg  [NPIN-1:0] s3_reg;
    reg  [NPIN-1:0] lvl_reg;
    wire [NPIN-1:0] lvlNext;
    wire [NPIN-1:0] rise;
    reg  [`RSPS_DATA_W-1:0] smp1_reg;
    reg  [`RSPS_DATA_W-1:0] smp2_reg;
    reg  [`RSPS_PTR_W-1:0]  readRow_next;
    reg  [`RSPS_PTR_W-1:0]  resetRow_next;
    reg  [`RSPS_PTR_W-1:0]  column_next;
    reg  [`RSPS_PTR_W-1:0]  rowStep;
    reg  [`RSPS_PTR_W-1:0]  diff;
    reg                     pushValid;
    wire                    pushReady;
    wire                    fifoValid;
    wire [`RSPS_DATA_W-1:0] fifoData;
    wire                    take;
    assign pinIn = {viewfinderEn, colSync, colClk, resetRowSync, resetRowClk,
                    readRowSync, readRowClk};
    genvar g;
    generate
        for (g = 0; g < NPIN; g = g + 1) begin : gSync
            // stage two and three must agree before a level is believed
            assign lvlNext[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : lvl_reg[g];
            assign rise[g]    = lvlNext[g] && !lvl_reg[g];
        end
    endgenerate
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s1_reg   <= {NPIN{1'b0}};
            s2_reg   <= {NPIN{1'b0}};
            s3_reg   <= {NPIN{1'b0}};
            lvl_reg  <= {NPIN{1'b0}};
            smp1_reg <= 10'h000;
            smp2_reg <= 10'h000;
        end else begin
            s1_reg   <= pinIn;
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            lvl_reg  <= lvlNext;
            smp1_reg <= pixelSample;
            smp2_reg <= smp1_reg;
        end
    end
    // wrap an index at the array edge, dummy lines included
    function [`RSPS_PTR_W-1:0] advance;
        input [`RSPS_PTR_W-1:0] cur;
        input [`RSPS_PTR_W-1:0] step;
        input [`RSPS_PTR_W-1:0] lim;
        reg   [`RSPS_PTR_W:0]   sum;
        begin
            sum = {1'b0, cur} + {1'b0, step};
            if (sum >= {1'b0, lim}) begin
                advance = `RSPS_FIRST_POS;
            end else begin
                advance = sum[`RSPS_PTR_W-1:0];
            end
        end
    endfunction
    always @* begin
        rowStep = lvl_reg[6] ? `RSPS_SUB_STEP : 11'h0_001;
        readRow_next  = readRow;
        resetRow_next = resetRow;
        column_next   = column;
        if (rise[1]) begin
            readRow_next = `RSPS_FIRST_POS;
        end else if (rise[0]) begin
            readRow_next = advance(readRow, rowStep, `RSPS_ROWS);
        end
        if (rise[3]) begin
            resetRow_next = `RSPS_FIRST_POS;
        end else if (rise[2]) begin
            resetRow_next = advance(resetRow, rowStep, `RSPS_ROWS);
        end
        if (rise[5]) begin
            column_next = `RSPS_FIRST_POS;
        end else if (rise[4]) begin
            column_next = advance(column, rowStep, `RSPS_COLS);
        end
        // exposure in whole lines: distance from reset row back to readout row
        if (resetRow_next >= readRow_next) begin
            diff = resetRow_next - readRow_next;
        end else begin
            diff = resetRow_next + `RSPS_ROWS - readRow_next;
        end
    end
    assign take = fifoValid && (!pixelValid || pixelReady);
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            readRow    <= 11'h0_000;
            resetRow   <= 11'h0_000;
            column     <= 11'h0_000;
            integLines <= 11'h0_000;
            pushValid  <= 1'b0;
            pixelValid <= 1'b0;
            pixelData  <= 10'h000;
            overflow   <= 1'b0;
        end else begin
            readRow    <= readRow_next;
            resetRow   <= resetRow_next;
            column     <= column_next;
            integLines <= diff;
            // one word per column step; sample aligned with the delayed clock edge
            pushValid  <= rise[4];
            if (pushValid && !pushReady) begin
                overflow <= 1'b1; // words are lost, the pixel stream cannot pause
            end else if (rise[1]) begin
                overflow <= 1'b0;
            end
            if (take) begin
                pixelValid <= 1'b1;
                pixelData  <= fifoData;
            end else if (pixelReady) begin
                pixelValid <= 1'b0;
            end
        end
    end
    rsps_fifo #(
        .WIDTH (`RSPS_DATA_W),
        .DEPTH (`RSPS_FIFO_DEPTH),
        .AW    (`RSPS_FIFO_AW)
    ) uFifo (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .inValid  (pushValid),
        .inReady  (pushReady),
        .inData   (smp2_reg),
        .outValid (fifoValid),
        .outReady (take),
        .outData  (fifoData)
    );
endmodule

// pixel word buffer, flip-flop storage; a full buffer refuses the writer
module rsps_fifo #(
    parameter WIDTH = 10,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             ref_clk,
    input  wire             resetn,
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0]    wrPtr_reg;
    reg [AW-1:0]    rdPtr_reg;
    reg [AW:0]      count_reg;
    wire            doWr;
    wire            doRd;
    assign inReady  = (count_reg != DEPTH[AW:0]);
    assign outValid = (count_reg != {(AW+1){1'b0}});
    assign outData  = mem_reg[rdPtr_reg];
    assign doWr     = inValid && inReady;
    assign doRd     = outValid && outReady;
    always @(posedge ref_clk) begin
        if (doWr) begin
            mem_reg[wrPtr_reg] <= inData;
        end
    end
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wrPtr_reg <= {AW{1'b0}};
            rdPtr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (doWr) begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (doRd) begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
            if (doWr && !doRd) begin
                count_reg <= count_reg + 1'b1;
            end else if (doRd && !doWr) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* rsps_pixel_scan_checker.sv */
// Purpose: port checks of the pixel scan block
// Assumes: one clock, async active-low reset
// Notes: pointer steps judged where the output moves
`timescale 1ns/1ns
`default_nettype none
module rsps_pixel_scan_checker (
    input wire logic        ref_clk,
    input wire logic        resetn,
    input wire logic        pixelReady,
    input wire logic        pixelValid,
    input wire logic [9:0]  pixelData,
    input wire logic [10:0] readRow,
    input wire logic [10:0] resetRow,
    input wire logic [10:0] column,
    input wire logic [10:0] integLines
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence s_push;
        $changed(column) && column != 11'h0_000;
    endsequence
    a_row_step: assert property ($changed(readRow) |-> readRow < 11'h0_004
        || readRow == $past(readRow) + 11'h0_001 || readRow == $past(readRow) + 11'h0_004)
        else $error("read row moved by a wrong step");
    a_reset_step: assert property ($changed(resetRow) |-> resetRow < 11'h0_004
        || resetRow == $past(resetRow) + 11'h0_001 || resetRow == $past(resetRow) + 11'h0_004)
        else $error("reset row moved by a wrong step");
    a_col_step: assert property ($changed(column) |-> column < 11'h0_004
        || column == $past(column) + 11'h0_001 || column == $past(column) + 11'h0_004)
        else $error("column moved by a wrong step");
    a_row_bound: assert property (readRow < 11'h0_406 && resetRow < 11'h0_406)
        else $error("row pointer beyond the array");
    a_col_bound: assert property (column < 11'h0_506)
        else $error("column pointer beyond the array");
    // distance moves in the same cycle as the pointers, no lag
    a_integ_dist: assert property (integLines == ((resetRow >= readRow)
        ? resetRow - readRow : resetRow + 11'h0_406 - readRow))
        else $error("integration distance wrong");
    a_word_hold: assert property (pixelValid && !pixelReady |=> pixelValid
        && $stable(pixelData))
        else $error("pixel word dropped before taken");
    a_push_valid: assert property (s_push |-> ##[1:4] pixelValid)
        else $error("column step gave no pixel word");
endmodule
bind rsps_pixel_scan rsps_pixel_scan_checker chk (.ref_clk(ref_clk), .resetn(resetn),
    .pixelReady(pixelReady), .pixelValid(pixelValid), .pixelData(pixelData),
    .readRow(readRow), .resetRow(resetRow), .column(column), .integLines(integLines));
`default_nettype wire

/* rsps_ctrl_model.sv */
// Purpose: outside timing controller and pixel taker
// Assumes: pin pulses far slower than ref_clk
// Notes: pins: 0 readClk 1 readSync 2 resetClk 3 resetSync 4 colClk 5 colSync
`timescale 1ns/1ns
`default_nettype none
module rsps_ctrl_model #(
    parameter SAMPLE_LEAD = 1
) (
    input  wire logic       ref_clk,
    output var  logic [5:0] pins,
    output var  logic [9:0] pixelSample,
    output var  logic       pixelReady
);
    initial begin
        pins = 6'h00;
        pixelSample = 10'h000;
        pixelReady = 1'b1;
    end
    task pulse(input integer n, input [9:0] v);
        begin
            @(posedge ref_clk) #2;
            pixelSample = v;
            // converter word leads the column clock by a tunable phase
            if (SAMPLE_LEAD > 0) begin
                repeat (SAMPLE_LEAD) @(posedge ref_clk);
                #2;
            end
            pins[n] = 1'b1;
            repeat (5) @(posedge ref_clk);
            #2 pins[n] = 1'b0;
            // slow pulses keep the pin rate within sampling reach
            repeat (5) @(posedge ref_clk);
        end
    endtask
    task set_ready(input r);
        begin
            pixelReady = r;
        end
    endtask
endmodule
`default_nettype wire

/* rsps_pixel_scan_tb.sv */
// Purpose: self-checking bench of the pixel scan block
// Assumes: 25 MHz ref_clk
// Notes: pins come from the controller model
`timescale 1ns/1ns
`default_nettype none
module rsps_pixel_scan_tb;
    reg          ref_clk, resetn, viewfinderEn;
    wire [5:0]   pins;
    wire [9:0]   pixelSample, pixelData;
    wire         pixelReady, pixelValid, overflow;
    wire [10:0]  readRow, resetRow, column, integLines;
    integer      miscompares, compares, i, j;
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    rsps_ctrl_model ctrl (.ref_clk(ref_clk), .pins(pins), .pixelSample(pixelSample),
        .pixelReady(pixelReady));
    rsps_pixel_scan uut (.ref_clk(ref_clk), .resetn(resetn), .readRowClk(pins[0]),
        .readRowSync(pins[1]), .resetRowClk(pins[2]), .resetRowSync(pins[3]),
        .colClk(pins[4]), .colSync(pins[5]), .viewfinderEn(viewfinderEn),
        .pixelSample(pixelSample), .pixelReady(pixelReady), .pixelValid(pixelValid),
        .pixelData(pixelData), .readRow(readRow), .resetRow(resetRow), .column(column),
        .integLines(integLines), .overflow(overflow));
    task check(input [10:0] seen, input [10:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task t_rows;
        begin
            ctrl.pulse(1, 0);
            ctrl.pulse(3, 0);
            for (i = 0; i < 3; i = i + 1) ctrl.pulse(0, 0);
            for (i = 0; i < 5; i = i + 1) ctrl.pulse(2, 0);
            check(readRow, 11'h0_003);
            check(resetRow, 11'h0_005);
            check(integLines, 11'h0_002);
            ctrl.pulse(3, 0);
            check(integLines, 11'h0_403);
            ctrl.pulse(1, 0);
            check(readRow, 11'h0_000);
        end
    endtask
    task t_view;
        begin
            #2 viewfinderEn = 1'b1;
            // no amplifier pins here; column restart stands before each row run
            ctrl.pulse(5, 0);
            for (i = 0; i < 2; i = i + 1) ctrl.pulse(4, 0);
            for (i = 0; i < 2; i = i + 1) ctrl.pulse(0, 0);
            ctrl.pulse(2, 0);
            check(column, 11'h0_008);
            check(readRow, 11'h0_008);
            check(resetRow, 11'h0_004);
            check(integLines, 11'h0_402);
            #2 viewfinderEn = 1'b0;
        end
    endtask
    task t_fill;
        begin
            #2 ctrl.set_ready(1'b0);
            // more words than the buffer can hold, far side stalled
            for (i = 0; i < 40; i = i + 1) ctrl.pulse(4, i);
            check(overflow, 11'h0_001);
            #2 ctrl.set_ready(1'b1);
            j = 0;
            repeat (200) @(negedge ref_clk) if (pixelValid && j < 32) begin
                check(pixelData, j);
                j = j + 1;
            end
            check(j, 11'h0_020);
            ctrl.pulse(1, 0);
            check(overflow, 11'h0_000);
        end
    endtask
    task t_wrap;
        begin
            for (i = 0; i < 1029; i = i + 1) ctrl.pulse(0, 0);
            check(readRow, 11'h0_405);
            ctrl.pulse(0, 0);
            check(readRow, 11'h0_000);
            ctrl.pulse(5, 0);
            for (i = 0; i < 1286; i = i + 1) ctrl.pulse(4, 0);
            check(column, 11'h0_000);
        end
    endtask
    task test_done;
        begin
            if (miscompares == 0 && compares > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask
    initial begin
        #3000000;
        miscompares = miscompares + 1;
        test_done;
    end
    initial begin
        resetn = 1'b0;
        viewfinderEn = 1'b0;
        miscompares = 0;
        compares = 0;
        repeat (2) @(posedge ref_clk);
        #2 resetn = 1'b1;
        t_rows;
        t_view;
        t_fill;
        t_wrap;
        test_done;
    end
endmodule
`default_nettype wire
